//--- logic/fwd_link_terminal.sv
/*
  terminal end: checks frame sync and crc32, parses gse packets, filters by label, delivers sdus.
  assumes the feeder frames data fields on the link and the user drains sdu bytes with sduReady.
*/
// Notes on behaviour
// [R01] accept no-label, 3-byte and 6-byte labels mixed
// [R02] feeder never re-uses labels
// [R03] sync 0x00 frames accepted when enabled
// [R04] sync 0x01 frames carry trailing crc32
// [R05] crc32 is last four data-field bytes
// [R06] crc covers data field minus crc
// [R07] crc32 same as gse fragment crc
// [R08] signalling sdus up to 4095 bytes
// [R09] ipv4 management sdus up to 1500 bytes
// [R10] other sdus 1500 or larger admin limit
// [R11] label type 2 broadcast signalling, no label
// [R12] label type 0 carries hardware id
// [R13] 48-bit hardware id match means ours
// [R14] dispatch by the listed protocol types
// [R15] types from 0x600 are ethertypes
// [R16] unsupported protocol types silently dropped
// [R17] feeder limits unsupported protocol types
// [R18] label type 1 matches an interface address
// [R19] crc failure flags the frame's packets bad; code only pulses frameCrcError after the last byte
`timescale 1ns/1ns
module fwd_link_terminal #(
  parameter int NUM_IF = 2
) (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  fwd_link_if.terminal                link,
  input  wire logic                   acceptPlain,
  input  wire logic [47:0]            hwId,
  input  wire logic [NUM_IF-1:0][23:0] linkAddr,
  input  wire logic [15:0]            mtuAdmin,
  input  wire logic                   sduReady,
  output logic                        sduValid,
  output logic [7:0]                  sduData,
  output logic                        sduFirst,
  output logic                        sduLast,
  output fwd_link_pkg::sdu_class_t    sduClass,
  output logic [$clog2(NUM_IF)-1:0]   sduIf,
  output logic                        frameDone,
  output logic                        frameCrcError,
  output logic                        frameRejected
);
  localparam int IFW = $clog2(NUM_IF);
  typedef enum logic [2:0] {S_HDR0, S_HDR1, S_PT0, S_PT1, S_LABEL, S_DATA, S_SKIP, S_PAD} parse_state_t;
  typedef logic [33:0] entry_t;

  entry_t       buf_q [fwd_link_pkg::BUF_DEPTH];
  logic         wrPtr_q, rdPtr_q, linkReady_q;
  logic [1:0]   count_q, countD;
  parse_state_t state_q, stateD;
  logic [7:0]   sync_q, ptHi_q;
  logic [15:0]  left_q, ptype_q;
  logic [31:0]  crcCalc_q, crcRx_q;
  logic         startEnd_q, firstPend_q;
  logic [1:0]   lt_q;
  logic [3:0]   lenHi_q, labLeft_q, labLen;
  logic [11:0]  gseLeft_q;
  logic [47:0]  label_q;
  logic         sduValid_q, sduFirst_q, sduLast_q, done_q, crcErr_q, rej_q;
  logic [7:0]   sduData_q;
  fwd_link_pkg::sdu_class_t sduClass_q, cls;
  logic [IFW-1:0] sduIf_q, hitIdx;
  logic           clsOk, addrOk;
  logic [NUM_IF-1:0] linkHit;

  // two-entry buffer: a stalled sdu consumer holds the link, no byte is lost
  wire         push  = link.valid && linkReady_q;
  wire         pop   = count_q != 2'h0 && (!sduValid_q || sduReady);
  wire entry_t head  = buf_q[rdPtr_q];
  wire         hFirst = head[33];
  wire         hLast  = head[32];
  wire [7:0]   hSync  = head[31:24];
  wire [15:0]  hDfl   = head[23:8];
  wire [7:0]   hByte  = head[7:0];

  assign countD = count_q + {1'b0, push} - {1'b0, pop};

  // frame level context; the first byte restarts it
  wire [7:0]   curSync   = hFirst ? hSync : sync_q;
  wire [15:0]  left      = hFirst ? hDfl : left_q;
  wire         hasCrc    = curSync == fwd_link_pkg::SYNC_CRC; // [R04]
  wire         frameOk   = hasCrc || (curSync == fwd_link_pkg::SYNC_PLAIN && acceptPlain); // [R03]
  wire         isCrcByte = hasCrc && left <= fwd_link_pkg::CRC_BYTES; // [R05]
  wire         consume   = pop && frameOk && !isCrcByte;
  wire [31:0]  crcBase   = hFirst ? fwd_link_pkg::CRC_INIT : crcCalc_q;
  wire [31:0]  crcNext   = fwd_link_pkg::crc32_byte(crcBase, hByte); // [R06] [R07]
  wire [31:0]  crcRxNext = {crcRx_q[23:0], hByte};
  wire         crcBad    = pop && hLast && hasCrc && crcRxNext != crcBase; // [R19]

  // packet level decode
  wire parse_state_t st   = hFirst ? S_HDR0 : state_q;
  wire [11:0]  hdrLen     = {lenHi_q, hByte};
  wire         lenEnd     = gseLeft_q == 12'h001;
  wire [15:0]  ptypeNow   = (st == S_PT1) ? {ptHi_q, hByte} : ptype_q;
  wire [47:0]  labelNext  = {label_q[39:0], hByte};
  wire         decideNow  = (st == S_PT1 && labLen == fwd_link_pkg::LABEL_LEN_NONE) ||
                            (st == S_LABEL && labLeft_q == 4'h1);
  wire [15:0]  sduLen     = {4'h0, gseLeft_q - 12'h001};
  wire [15:0]  otherMtu   = mtuAdmin > fwd_link_pkg::MTU_STD ? mtuAdmin : fwd_link_pkg::MTU_STD; // [R10]
  wire         mgmt       = lt_q == fwd_link_pkg::LT_LINK && hitIdx == '0 && ptypeNow == fwd_link_pkg::PT_IPV4;
  wire [15:0]  mtuLimit   = (cls == fwd_link_pkg::CLS_SIG) ? fwd_link_pkg::MTU_SIG : // [R08]
                            mgmt ? fwd_link_pkg::MTU_STD : otherMtu; // [R09]
  wire         accept     = addrOk && clsOk && sduLen <= mtuLimit;
  wire         hwHit      = labelNext == hwId; // [R13]

  assign labLen = (lt_q == fwd_link_pkg::LT_HWID) ? fwd_link_pkg::LABEL_LEN_HWID : // [R01] [R12]
                  (lt_q == fwd_link_pkg::LT_LINK) ? fwd_link_pkg::LABEL_LEN_LINK : fwd_link_pkg::LABEL_LEN_NONE;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IF; gi++) begin : g_if
      assign linkHit[gi] = labelNext[23:0] == linkAddr[gi]; // [R18]
    end
  endgenerate

  always_comb begin
    hitIdx = '0;
    for (int i = NUM_IF - 1; i >= 0; i--) begin
      if (linkHit[i]) begin
        hitIdx = IFW'(i);
      end
    end
  end

  // re-use type 3 never appears on this link, so it is simply dropped
  always_comb begin
    case (lt_q)
      fwd_link_pkg::LT_HWID: addrOk = hwHit; // [R12] [R13]
      fwd_link_pkg::LT_LINK: addrOk = |linkHit; // [R18]
      fwd_link_pkg::LT_NONE: addrOk = 1'b1; // [R11]
      default:               addrOk = 1'b0; // [R02]
    endcase
  end

  always_comb begin
    clsOk = 1'b1;
    case (ptypeNow) // [R14]
      fwd_link_pkg::PT_NCR:  cls = fwd_link_pkg::CLS_NCR;
      fwd_link_pkg::PT_SIG:  cls = fwd_link_pkg::CLS_SIG;
      fwd_link_pkg::PT_CONN: cls = fwd_link_pkg::CLS_CONN;
      fwd_link_pkg::PT_SEC:  cls = fwd_link_pkg::CLS_SEC;
      fwd_link_pkg::PT_ENC:  cls = fwd_link_pkg::CLS_ENC;
      default: begin
        cls   = fwd_link_pkg::CLS_ETHER;
        clsOk = ptypeNow >= fwd_link_pkg::PT_ETHER_MIN; // [R15] [R16]
      end
    endcase
  end

  always_comb begin
    stateD = st;
    case (st)
      S_HDR0:  stateD = (hByte[7:4] == fwd_link_pkg::HDR_PAD_NIBBLE) ? S_PAD : S_HDR1;
      S_HDR1:  stateD = (hdrLen == 12'h000) ? S_HDR0 : (startEnd_q ? S_PT0 : S_SKIP);
      S_PT0:   stateD = S_PT1;
      S_PT1:   stateD = decideNow ? (accept ? S_DATA : S_SKIP) : S_LABEL;
      S_LABEL: stateD = decideNow ? (accept ? S_DATA : S_SKIP) : S_LABEL;
      S_DATA:  stateD = S_DATA;
      S_SKIP:  stateD = S_SKIP;
      S_PAD:   stateD = S_PAD;
      default: stateD = S_HDR0;
    endcase
    if (st != S_HDR0 && st != S_HDR1 && st != S_PAD && lenEnd) begin
      stateD = S_HDR0;
    end
  end

  assign link.ready    = linkReady_q;
  assign sduValid      = sduValid_q;
  assign sduData       = sduData_q;
  assign sduFirst      = sduFirst_q;
  assign sduLast       = sduLast_q;
  assign sduClass      = sduClass_q;
  assign sduIf         = sduIf_q;
  assign frameDone     = done_q;
  assign frameCrcError = crcErr_q;
  assign frameRejected = rej_q;

  always_ff @(posedge clock) begin
    if (push) begin
      buf_q[wrPtr_q] <= {link.first, link.last, link.sync, link.data_field_length, link.data};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_q     <= 2'h0;
      wrPtr_q     <= 1'b0;
      rdPtr_q     <= 1'b0;
      linkReady_q <= 1'b0;
    end else begin
      count_q     <= countD;
      wrPtr_q     <= wrPtr_q ^ push;
      rdPtr_q     <= rdPtr_q ^ pop;
      linkReady_q <= countD != 2'(fwd_link_pkg::BUF_DEPTH);
    end
  end

  always_ff @(posedge clock) begin
    if (pop) begin
      sync_q    <= curSync;
      left_q    <= left - 16'h0001;
      crcCalc_q <= (frameOk && !isCrcByte) ? crcNext : crcBase;
      crcRx_q   <= isCrcByte ? crcRxNext : crcRx_q;
      state_q   <= consume ? stateD : st;
    end
    if (consume) begin
      gseLeft_q <= gseLeft_q - 12'h001;
      case (st)
        S_HDR0: begin
          startEnd_q <= hByte[fwd_link_pkg::HDR_START_BIT] & hByte[fwd_link_pkg::HDR_END_BIT];
          lt_q       <= hByte[fwd_link_pkg::HDR_LT_MSB:fwd_link_pkg::HDR_LT_LSB];
          lenHi_q    <= hByte[fwd_link_pkg::HDR_LEN_MSB:0];
        end
        S_HDR1:  gseLeft_q <= hdrLen;
        S_PT0:   ptHi_q <= hByte;
        S_PT1: begin
          ptype_q   <= ptypeNow;
          labLeft_q <= labLen;
        end
        S_LABEL: begin
          label_q   <= labelNext;
          labLeft_q <= labLeft_q - 4'h1;
        end
        default: ;
      endcase
      if (decideNow) begin
        sduClass_q  <= cls;
        sduIf_q     <= hitIdx;
        firstPend_q <= 1'b1;
      end
    end
    if (consume && st == S_DATA) begin
      sduValid_q  <= 1'b1;
      sduData_q   <= hByte;
      sduFirst_q  <= firstPend_q;
      sduLast_q   <= lenEnd || hLast;
      firstPend_q <= 1'b0;
    end else if (sduReady) begin
      sduValid_q <= 1'b0;
    end
    done_q   <= pop && hLast;
    crcErr_q <= crcBad; // [R19]
    rej_q    <= pop && hFirst && !frameOk;
    if (!resetn) begin
      state_q     <= S_HDR0;
      sync_q      <= 8'h00;
      left_q      <= 16'h0000;
      crcCalc_q   <= fwd_link_pkg::CRC_INIT;
      crcRx_q     <= 32'h00000000;
      gseLeft_q   <= 12'h000;
      startEnd_q  <= 1'b0;
      lt_q        <= 2'h0;
      lenHi_q     <= 4'h0;
      ptHi_q      <= 8'h00;
      ptype_q     <= 16'h0000;
      labLeft_q   <= 4'h0;
      label_q     <= 48'h000000000000;
      firstPend_q <= 1'b0;
      sduValid_q  <= 1'b0;
      sduData_q   <= 8'h00;
      sduFirst_q  <= 1'b0;
      sduLast_q   <= 1'b0;
      sduClass_q  <= fwd_link_pkg::CLS_NCR;
      sduIf_q     <= '0;
      done_q      <= 1'b0;
      crcErr_q    <= 1'b0;
      rej_q       <= 1'b0;
    end
  end
endmodule

//--- logic/fwd_link_pkg.sv
/*
  constants, types and the frame crc step shared by both ends of the forward link.
  assumes nothing of its surroundings.
*/
package fwd_link_pkg;
  localparam logic [7:0]  SYNC_PLAIN     = 8'h00;
  localparam logic [7:0]  SYNC_CRC       = 8'h01;
  localparam logic [15:0] CRC_BYTES      = 16'h0004;
  localparam logic [31:0] CRC_POLY       = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT       = 32'hffffffff;
  localparam int          BUF_DEPTH      = 2;
  localparam int          HDR_START_BIT  = 7;
  localparam int          HDR_END_BIT    = 6;
  localparam int          HDR_LT_MSB     = 5;
  localparam int          HDR_LT_LSB     = 4;
  localparam int          HDR_LEN_MSB    = 3;
  localparam logic [3:0]  HDR_PAD_NIBBLE = 4'h0;
  localparam logic [1:0]  LT_HWID        = 2'h0;
  localparam logic [1:0]  LT_LINK        = 2'h1;
  localparam logic [1:0]  LT_NONE        = 2'h2;
  localparam logic [3:0]  LABEL_LEN_HWID = 4'h6;
  localparam logic [3:0]  LABEL_LEN_LINK = 4'h3;
  localparam logic [3:0]  LABEL_LEN_NONE = 4'h0;
  localparam logic [15:0] PT_NCR         = 16'h0081;
  localparam logic [15:0] PT_SIG         = 16'h0082;
  localparam logic [15:0] PT_CONN        = 16'h0083;
  localparam logic [15:0] PT_SEC         = 16'h0085;
  localparam logic [15:0] PT_ENC         = 16'h0086;
  localparam logic [15:0] PT_ETHER_MIN   = 16'h0600;
  localparam logic [15:0] PT_IPV4        = 16'h0800;
  localparam logic [15:0] MTU_SIG        = 16'h0fff;
  localparam logic [15:0] MTU_STD        = 16'h05dc;

  typedef enum logic [2:0] {CLS_NCR, CLS_SIG, CLS_CONN, CLS_SEC, CLS_ENC, CLS_ETHER} sdu_class_t;

  // msb first, no reflection, no final inversion
  function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] data);
    logic [31:0] c;
    c = crc ^ {data, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      c = c[31] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

//--- logic/fwd_link_if.sv
/*
  byte stream of baseband data fields from feeder to terminal.
  assumes both ends share one clock; sync and dfl are read with first.
*/
`timescale 1ns/1ns
interface fwd_link_if;
  logic        valid;
  logic        ready;
  logic        first;
  logic        last;
  logic [7:0]  data;
  logic [7:0]  sync;
  logic [15:0] data_field_length;

  modport feeder (output valid, first, last, data, sync, data_field_length, input ready);
  modport terminal (input valid, first, last, data, sync, data_field_length, output ready);
endinterface

//--- logic/fwd_link_feeder.sv
/*
  feeder end: frames a stream of ready-made gse bytes and appends the crc32 trailer.
  assumes the user side presents one frame descriptor, then the data bytes one at a time.
*/
`timescale 1ns/1ns
module fwd_link_feeder (
  input  wire logic         clock,
  input  wire logic         resetn,
  fwd_link_if.feeder        link,
  input  wire logic         frameValid,
  input  wire logic         frameCrc,
  input  wire logic [15:0]  frameDfl,
  output logic              frameTaken,
  input  wire logic         pldValid,
  input  wire logic [7:0]   pldData,
  output logic              pldTaken,
  output logic              busy
);
  typedef enum logic [1:0] {F_IDLE, F_DATA, F_CRC} feed_state_t;

  feed_state_t state_q;
  logic        valid_q, first_q, last_q, firstPend_q, frameTaken_q, pldTaken_q;
  logic [7:0]  data_q, sync_q;
  logic [15:0] dfl_q, left_q, dataLeft_q;
  logic [31:0] crc_q;

  wire         canLoad  = !valid_q || link.ready;
  wire         takeByte = state_q == F_DATA && canLoad && pldValid && !pldTaken_q;
  wire         sendCrc  = state_q == F_CRC && canLoad;
  wire  [15:0] dataLen  = frameCrc ? frameDfl - fwd_link_pkg::CRC_BYTES : frameDfl;

  assign link.valid = valid_q;
  assign link.first = first_q;
  assign link.last  = last_q;
  assign link.data  = data_q;
  assign link.sync  = sync_q;
  assign link.data_field_length   = dfl_q;
  assign frameTaken = frameTaken_q;
  assign pldTaken   = pldTaken_q;
  assign busy       = state_q != F_IDLE;

  always_ff @(posedge clock) begin
    frameTaken_q <= 1'b0;
    pldTaken_q   <= 1'b0;
    if (canLoad) begin
      valid_q <= 1'b0;
    end
    // a last byte still waiting on ready keeps its frame's sync and length
    if (state_q == F_IDLE && frameValid && canLoad) begin
      frameTaken_q <= 1'b1;
      sync_q       <= frameCrc ? fwd_link_pkg::SYNC_CRC : fwd_link_pkg::SYNC_PLAIN; // [R04]
      dfl_q        <= frameDfl;
      left_q       <= frameDfl;
      dataLeft_q   <= dataLen; // [R05]
      crc_q        <= fwd_link_pkg::CRC_INIT;
      firstPend_q  <= 1'b1;
      state_q      <= (dataLen == 16'h0000) ? F_CRC : F_DATA;
    end
    if (takeByte || sendCrc) begin
      valid_q     <= 1'b1;
      first_q     <= firstPend_q;
      last_q      <= left_q == 16'h0001;
      firstPend_q <= 1'b0;
      left_q      <= left_q - 16'h0001;
    end
    if (takeByte) begin
      data_q     <= pldData;
      pldTaken_q <= 1'b1;
      crc_q      <= fwd_link_pkg::crc32_byte(crc_q, pldData); // [R06] [R07]
      dataLeft_q <= dataLeft_q - 16'h0001;
      if (dataLeft_q == 16'h0001) begin
        state_q <= (sync_q == fwd_link_pkg::SYNC_CRC) ? F_CRC : F_IDLE;
      end
    end
    if (sendCrc) begin
      data_q <= crc_q[31:24]; // [R05]
      crc_q  <= {crc_q[23:0], 8'h00};
      if (left_q == 16'h0001) begin
        state_q <= F_IDLE;
      end
    end
    if (!resetn) begin
      state_q      <= F_IDLE;
      valid_q      <= 1'b0;
      first_q      <= 1'b0;
      last_q       <= 1'b0;
      firstPend_q  <= 1'b0;
      frameTaken_q <= 1'b0;
      pldTaken_q   <= 1'b0;
      data_q       <= 8'h00;
      sync_q       <= 8'h00;
      dfl_q        <= 16'h0000;
      left_q       <= 16'h0000;
      dataLeft_q   <= 16'h0000;
      crc_q        <= fwd_link_pkg::CRC_INIT;
    end
  end
endmodule

//--- testbench/fwd_link_assertions.sv
/*
  concurrent checks on the link between feeder and terminal.
  assumes one clock for both ends; instantiated beside the link interface.
*/
`timescale 1ns/1ns
module fwd_link_assertions (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        valid,
  input wire logic        ready,
  input wire logic        first,
  input wire logic        last,
  input wire logic [7:0]  data,
  input wire logic [7:0]  sync,
  input wire logic [15:0] data_field_length
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [15:0] idxQ;
  logic [31:0] crcQ;
  wire logic [15:0] idx     = first ? 16'h0000 : idxQ;
  wire logic [31:0] cur     = first ? 32'hffffffff : crcQ;
  wire logic [15:0] crcPos  = data_field_length - 16'h0004;
  wire logic [15:0] k       = idx - crcPos;
  wire logic [1:0]  sh      = 2'h3 - k[1:0];
  wire logic [7:0]  crcByte = cur[{sh, 3'h0} +: 8];
  wire logic        crcSel  = sync == fwd_link_pkg::SYNC_CRC;

  // own copy, so a wrong package step cannot hide
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {d, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      x = x[31] ? ((x << 1) ^ 32'h04c11db7) : (x << 1);
    end
    return x;
  endfunction

  always_ff @(posedge clock) begin
    if (!resetn) begin
      idxQ <= 16'h0000;
      crcQ <= 32'h00000000;
    end else if (valid && ready) begin
      idxQ <= last ? 16'h0000 : idx + 16'h0001;
      crcQ <= (idx < crcPos) ? step(cur, data) : cur;
    end
  end

  sequence sLastTaken;
    valid && ready && last;
  endsequence

  a_valid_holds: assert property (valid && !ready |=> valid && $stable(data) && $stable(first) && $stable(last))
    else $error("link byte changed before it was taken");
  a_sync_legal: assert property (valid && first |-> sync == fwd_link_pkg::SYNC_PLAIN || crcSel)
    else $error("frame sync is neither plain nor crc");
  a_fields_stable: assert property (valid && !first |-> $stable(sync) && $stable(data_field_length))
    else $error("sync or length changed inside a frame");
  a_crc_room: assert property (valid && first && crcSel |-> data_field_length >= fwd_link_pkg::CRC_BYTES)
    else $error("crc frame shorter than its trailer");
  a_frame_length: assert property (sLastTaken |-> idx + 16'h0001 == data_field_length)
    else $error("frame byte count differs from its length");
  a_frame_order: assert property (valid && ready |-> first == (idxQ == 16'h0000))
    else $error("first flag out of place");
  a_crc_trailer: assert property (valid && crcSel && idx >= crcPos |-> data == crcByte)
    else $error("crc trailer byte wrong");
  a_plain_nonempty: assert property (valid && first && !crcSel |-> data_field_length != 16'h0000)
    else $error("plain frame with zero length");
endmodule

//--- testbench/forward_link_sdu_receiver_tb.sv
/*
  bench for both link ends: feeds frames through the feeder, collects terminal sdus.
  assumes logic/ compiled first; a second terminal is driven directly to break rules.
*/
`timescale 1ns/1ns
module forward_link_sdu_receiver_tb;
  logic             clock       = 1'b0;
  logic             resetn      = 1'b0;
  logic             frameValid  = 1'b0;
  logic             frameCrc    = 1'b0;
  logic [15:0]      frameDfl    = 16'h0000;
  logic             pldValid    = 1'b0;
  logic [7:0]       pldData     = 8'h00;
  logic [47:0]      hwId        = 48'h0a1b2c3d4e5f;
  logic [1:0][23:0] linkAddr    = {24'h05a5a5, 24'h00c3c3};
  logic [15:0]      mtuAdmin    = 16'h0000;
  logic             sduReady    = 1'b0;
  logic             stall       = 1'b1;
  logic             sawFull     = 1'b0;
  logic             acceptPlain = 1'b1;
  wire logic        frameTaken, pldTaken, sduValid, sduFirst, sduLast, sduIf, frameDone, frameCrcError, crcErr2, rej2;
  wire logic        frameRejected, busy;
  wire logic [7:0]  sduData;
  fwd_link_pkg::sdu_class_t sduClass;
  int               num_errors  = 0;
  int               cmp_count   = 0;
  int               cyc         = 0;
  int               doneCnt     = 0;
  int               crcCnt      = 0;
  int               crcCnt2     = 0;
  int               rejCnt2     = 0;
  int               rejCnt      = 0;
  logic [7:0]       fb[$];
  logic [14:0]      exp[$];
  logic [13:0]      got[$];

  fwd_link_if link ();
  fwd_link_if link2 ();
  fwd_link_feeder i_fwd_link_feeder (.clock(clock), .resetn(resetn), .link(link.feeder), .frameValid(frameValid),
    .frameCrc(frameCrc), .frameDfl(frameDfl), .frameTaken(frameTaken), .pldValid(pldValid), .pldData(pldData),
    .pldTaken(pldTaken), .busy(busy));
  fwd_link_terminal #(.NUM_IF(2)) i_fwd_link_terminal (.clock(clock), .resetn(resetn), .link(link.terminal),
    .acceptPlain(acceptPlain), .hwId(hwId), .linkAddr(linkAddr), .mtuAdmin(mtuAdmin), .sduReady(sduReady),
    .sduValid(sduValid), .sduData(sduData), .sduFirst(sduFirst), .sduLast(sduLast), .sduClass(sduClass),
    .sduIf(sduIf), .frameDone(frameDone), .frameCrcError(frameCrcError), .frameRejected(frameRejected));
  fwd_link_terminal #(.NUM_IF(2)) i_fwd_link_terminal_b (.clock(clock), .resetn(resetn), .link(link2.terminal),
    .acceptPlain(acceptPlain), .hwId(hwId), .linkAddr(linkAddr), .mtuAdmin(mtuAdmin), .sduReady(sduReady),
    .sduValid(),
    .sduData(), .sduFirst(), .sduLast(), .sduClass(), .sduIf(), .frameDone(), .frameCrcError(crcErr2),
    .frameRejected(rej2));
  fwd_link_assertions i_fwd_link_assertions (.clock(clock), .resetn(resetn), .valid(link.valid),
    .ready(link.ready), .first(link.first), .last(link.last), .data(link.data), .sync(link.sync), .data_field_length(link.data_field_length));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (resetn === 1'b1 && sduValid === 1'b1 && sduReady === 1'b1) begin
      got.push_back({sduClass, sduIf, sduFirst, sduLast, sduData});
    end
    doneCnt <= doneCnt + int'(frameDone === 1'b1);
    crcCnt <= crcCnt + int'(frameCrcError === 1'b1);
    crcCnt2 <= crcCnt2 + int'(crcErr2 === 1'b1);
    rejCnt2 <= rejCnt2 + int'(rej2 === 1'b1);
    rejCnt <= rejCnt + int'(frameRejected === 1'b1);
    if (link.valid === 1'b1 && link.ready === 1'b0) sawFull <= 1'b1;
    // slow consumer backs the buffer up into the feeder
    sduReady <= #1 (!stall || cyc % 7 == 0);
  end

  always @(posedge clock) begin
    if (cyc == 60000) begin
      num_errors++;
      end_sim();
    end
  end

  task check(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task end_sim;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one complete gse packet into fb; ok marks the bytes expected at the sdu side
  task pkt(input logic [1:0] lt, input logic [47:0] lab, input logic [15:0] pt, input int n, input logic ok,
           input logic [2:0] cls, input logic ifx);
    int          ll;
    logic [11:0] len;
    ll = (lt == fwd_link_pkg::LT_HWID) ? 6 : (lt == fwd_link_pkg::LT_LINK) ? 3 : 0;
    len = 12'(2 + ll + n);
    fb.push_back({2'b11, lt, len[11:8]});
    fb.push_back(len[7:0]);
    fb.push_back(pt[15:8]);
    fb.push_back(pt[7:0]);
    for (int i = ll - 1; i >= 0; i--) fb.push_back(lab[8*i +: 8]);
    for (int i = 0; i < n; i++) begin
      fb.push_back(8'(i + 48));
      if (ok) exp.push_back({lt == fwd_link_pkg::LT_LINK, cls, ifx, i == 0, i == n - 1, 8'(i + 48)});
    end
  endtask

  task send(input logic crc);
    frameCrc = crc;
    frameDfl = 16'(fb.size()) + (crc ? fwd_link_pkg::CRC_BYTES : 16'h0000);
    frameValid = 1'b1;
    do begin @(posedge clock); #1; end while (frameTaken !== 1'b1);
    frameValid = 1'b0;
    foreach (fb[i]) begin
      pldData = fb[i];
      pldValid = 1'b1;
      do begin @(posedge clock); #1; end while (pldTaken !== 1'b1);
    end
    pldValid = 1'b0;
    fb.delete();
  endtask

  // stands in for a feeder that may break the framing rules
  task send2(input logic [7:0] s);
    link2.sync = s;
    link2.data_field_length = 16'(fb.size());
    foreach (fb[i]) begin
      link2.valid = 1'b1;
      link2.first = (i == 0);
      link2.last = (i == fb.size() - 1);
      link2.data = fb[i];
      // ready is registered, so its value here stands at the next edge
      while (link2.ready !== 1'b1) begin
        @(posedge clock);
        #1;
      end
      @(posedge clock);
      #1;
    end
    link2.valid = 1'b0;
    @(posedge clock);
    #1;
    fb.delete();
  endtask

  initial begin
    link2.valid = 1'b0;
    link2.first = 1'b0;
    link2.last = 1'b0;
    link2.data = 8'h00;
    link2.sync = 8'h00;
    link2.data_field_length = 16'h0000;
    repeat (16) @(posedge clock);
    #1 resetn = 1'b1;
    pkt(fwd_link_pkg::LT_NONE, 48'h0, fwd_link_pkg::PT_SIG, 5, 1'b1, fwd_link_pkg::CLS_SIG, 1'b0);
    pkt(fwd_link_pkg::LT_LINK, 48'(linkAddr[1]), fwd_link_pkg::PT_IPV4, 3, 1'b1, fwd_link_pkg::CLS_ETHER, 1'b1);
    pkt(fwd_link_pkg::LT_HWID, hwId, fwd_link_pkg::PT_NCR, 2, 1'b1, fwd_link_pkg::CLS_NCR, 1'b0);
    pkt(fwd_link_pkg::LT_LINK, 48'(linkAddr[0]), fwd_link_pkg::PT_ENC, 2, 1'b1, fwd_link_pkg::CLS_ENC, 1'b0);
    send(1'b1);
    check(32'(busy), 32'h1);
    while (doneCnt < 1) @(posedge clock);
    #1 stall = 1'b0;
    pkt(fwd_link_pkg::LT_HWID, hwId ^ 48'h1, fwd_link_pkg::PT_NCR, 2, 1'b0, 3'h0, 1'b0);
    pkt(fwd_link_pkg::LT_NONE, 48'h0, 16'h0084, 3, 1'b0, 3'h0, 1'b0);
    pkt(fwd_link_pkg::LT_NONE, 48'h0, fwd_link_pkg::PT_CONN, 2, 1'b1, fwd_link_pkg::CLS_CONN, 1'b0);
    pkt(fwd_link_pkg::LT_HWID, hwId, fwd_link_pkg::PT_SEC, 1, 1'b1, fwd_link_pkg::CLS_SEC, 1'b0);
    fb.push_back(8'h00);
    fb.push_back(8'h00);
    send(1'b0);
    mtuAdmin = 16'h0640;
    pkt(fwd_link_pkg::LT_LINK, 48'(linkAddr[0]), fwd_link_pkg::PT_IPV4, 1500, 1'b1, fwd_link_pkg::CLS_ETHER, 1'b0);
    pkt(fwd_link_pkg::LT_LINK, 48'(linkAddr[0]), fwd_link_pkg::PT_IPV4, 1501, 1'b0, 3'h0, 1'b0);
    pkt(fwd_link_pkg::LT_LINK, 48'(linkAddr[1]), 16'h86dd, 1600, 1'b1, fwd_link_pkg::CLS_ETHER, 1'b1);
    pkt(fwd_link_pkg::LT_LINK, 48'(linkAddr[1]), 16'h86dd, 1601, 1'b0, 3'h0, 1'b0);
    pkt(fwd_link_pkg::LT_NONE, 48'h0, fwd_link_pkg::PT_SIG, 1700, 1'b1, fwd_link_pkg::CLS_SIG, 1'b0);
    send(1'b1);
    while (doneCnt < 3) @(posedge clock);
    #1 acceptPlain = 1'b0;
    pkt(fwd_link_pkg::LT_NONE, 48'h0, fwd_link_pkg::PT_SIG, 2, 1'b0, 3'h0, 1'b0);
    send(1'b0);
    while (doneCnt < 4) @(posedge clock);
    #1 acceptPlain = 1'b1;
    pkt(fwd_link_pkg::LT_NONE, 48'h0, fwd_link_pkg::PT_SIG, 2, 1'b0, 3'h0, 1'b0);
    repeat (4) fb.push_back(8'h00);
    send2(fwd_link_pkg::SYNC_CRC);
    pkt(fwd_link_pkg::LT_NONE, 48'h0, fwd_link_pkg::PT_SIG, 2, 1'b0, 3'h0, 1'b0);
    send2(8'h02);
    repeat (20) @(posedge clock);
    check(32'(got.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      if (i < got.size()) check(got[i] & (exp[i][14] ? 14'h3fff : 14'h3bff), exp[i][13:0] & 14'h3bff | (exp[i][14] ? exp[i][13:0] & 14'h0400 : 14'h0));
    end
    check(32'(doneCnt), 32'h4);
    check(32'(rejCnt), 32'h1);
    check(32'(busy), 32'h0);
    check(32'(crcCnt), 32'h0);
    check(32'(crcCnt2), 32'h1);
    check(32'(rejCnt2), 32'h1);
    check(32'(sawFull), 32'h1);
    end_sim();
  end
endmodule
